// ---- verif/ppoc_port_ctl_asserts.sv ----
// Purpose: Checker for the port power block
// Assumes: Bound to ppoc_port_ctl, one clock
// Notes:   Sees top-level ports only
`timescale 1ns/1ps
module ppoc_port_chk (
  // Clock and reset
  input wire       i_core_clk,
  input wire       i_sys_rst,
  // Pins
  input wire [3:0] i_port_power_sense_pin,
  input wire [3:0] o_port_power_sense_pin,
  input wire [3:0] o_port_power_sense_pin_oe_n,
  input wire [3:0] o_port_pullup_en,
  input wire       i_shared_power_sense_pin,
  input wire       o_shared_power_sense_pin,
  input wire       o_shared_power_sense_pin_oe_n,
  input wire       o_shared_pullup_en,
  // Status
  input wire [3:0] o_oc_event,
  input wire       o_irq,
  // Bus
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // Age of the last low seen on a released pin
  reg [3:0] low_age_q;
  wire      low_seen = |(~i_port_power_sense_pin & o_port_power_sense_pin_oe_n) ||
                       (!i_shared_power_sense_pin && o_shared_power_sense_pin_oe_n);
  always @(posedge i_core_clk) begin
    if (i_sys_rst || low_seen) low_age_q <= 4'h0;
    else if (low_age_q != 4'hF) low_age_q <= low_age_q + 4'h1;
  end
  pin_low_a: assert property (o_port_power_sense_pin == 4'h0 && !o_shared_power_sense_pin)
    else $error("pin driven high");
  pullup_link_a: assert property (o_port_pullup_en == o_port_power_sense_pin_oe_n)
    else $error("pull-up not tied to release");
  shared_link_a: assert property (o_shared_pullup_en == o_shared_power_sense_pin_oe_n)
    else $error("shared pull-up not tied to release");
  gang_exclusive_a: assert property (o_shared_power_sense_pin_oe_n |-> o_port_power_sense_pin_oe_n == 4'h0)
    else $error("port pin released in ganged mode");
  fault_cause_a: assert property ((o_oc_event & ~$past(o_oc_event)) != 4'h0 |-> low_age_q < 4'h6)
    else $error("fault without recent low");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  reset_state_a: assert property ($fell(i_sys_rst) |-> o_port_power_sense_pin_oe_n == 4'h0 && !o_irq)
    else $error("outputs not at reset state");
  cover property (o_oc_event != 4'h0);
  cover property (o_shared_power_sense_pin_oe_n);
  cover property (o_irq);
endmodule // ppoc_port_chk

bind ppoc_port_ctl ppoc_port_chk u_chk (
  .i_core_clk                    (i_core_clk),
  .i_sys_rst                     (i_sys_rst),
  .i_port_power_sense_pin        (i_port_power_sense_pin),
  .o_port_power_sense_pin        (o_port_power_sense_pin),
  .o_port_power_sense_pin_oe_n   (o_port_power_sense_pin_oe_n),
  .o_port_pullup_en              (o_port_pullup_en),
  .i_shared_power_sense_pin      (i_shared_power_sense_pin),
  .o_shared_power_sense_pin      (o_shared_power_sense_pin),
  .o_shared_power_sense_pin_oe_n (o_shared_power_sense_pin_oe_n),
  .o_shared_pullup_en            (o_shared_pullup_en),
  .o_oc_event                    (o_oc_event),
  .o_irq                         (o_irq),
  .s_axi_bvalid                  (s_axi_bvalid),
  .s_axi_bready                  (s_axi_bready),
  .s_axi_arvalid                 (s_axi_arvalid),
  .s_axi_arready                 (s_axi_arready),
  .s_axi_rvalid                  (s_axi_rvalid),
  .s_axi_rready                  (s_axi_rready)
);

// ---- verif/ppoc_port_ctl_tb.sv ----
// Purpose: Self-checking bench for ppoc_port_ctl
// Assumes: Short filter counts, strap low until a mid-run reset
// Notes:   Bus answers checked from a queue
`timescale 1ns/1ps
module ppoc_port_ctl_tb;
  localparam integer SC = 20;
  localparam integer DC = 80;
  reg         clk = 1'b0, rst = 1'b1, strap = 1'b0, rdy = 1'b1;
  reg  [3:0]  req = 4'h0, strb = 4'hF;
  reg  [4:0]  flt = 5'h00;
  reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
  reg  [31:0] wdata = 32'h0, r;
  reg         awv = 1'b0, wv = 1'b0, arv = 1'b0;
  wire [3:0]  pin_i, pin_o, oe_n, pu, oc, chg;
  wire        sh_i, sh_o, sh_oe_n, sh_pu, irq, awr, wrdy, bv, arr, rv;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     fails = 0, checks_done = 0, cyc = 0;
  logic [33:0] expq[$];
  ppoc_switch_model u_sw (.i_core_clk(clk), .i_oe_n({sh_oe_n, oe_n}), .i_pu({sh_pu, pu}),
    .i_drv({sh_o, pin_o}), .i_flt(flt), .o_pin({sh_i, pin_i}));
  ppoc_port_ctl #(.SINGLE_CYC(SC), .DOUBLE_CYC(DC)) DUT (.i_core_clk(clk), .i_sys_rst(rst),
    .i_hub_pwr_req(req), .i_charge_enable_strap(strap), .i_port_power_sense_pin(pin_i),
    .o_port_power_sense_pin(pin_o), .o_port_power_sense_pin_oe_n(oe_n), .o_port_pullup_en(pu),
    .i_shared_power_sense_pin(sh_i), .o_shared_power_sense_pin(sh_o),
    .o_shared_power_sense_pin_oe_n(sh_oe_n), .o_shared_pullup_en(sh_pu), .o_oc_event(oc),
    .o_charge_port_en(chg), .o_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(rdy),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rdy));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input string n, input [33:0] e, input [33:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task automatic tk(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    begin
      expq.push_back({2'b00, 32'h0});
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wrdy) wv <= 1'b0;
      end while (!bv);
    end
  endtask
  task automatic rd(input [7:0] a, input [33:0] e);
    begin
      expq.push_back(e);
      araddr <= a;
      arv <= 1'b1;
      do begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
      end while (!rv);
    end
  endtask
  task automatic wrap_up;
    begin
      $display("Checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Answers matched in issue order; only one transfer is ever open
  always @(posedge clk) begin
    if (!rst && (rv || bv)) chk("axi_answer", expq.pop_front(), rv ? {rresp, rdata} : {bresp, 32'h0});
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      wrap_up;
    end
  end
  initial begin
    r = $urandom(32'hFC65);
    tk(16);
    rst <= 1'b0;
    tk(2);
    rd(8'h14, {2'b00, 32'h3});
    rd(8'h18, {2'b10, 32'h0});
    r = $urandom & 32'hF;
    req <= r[3:0];
    tk(4);
    chk("hub_power", r[3:0], oe_n);
    chk("pullup", r[3:0], pu);
    wr(8'h00, 32'h2);
    wr(8'h04, 32'hF);
    wr(8'h0C, 32'h1);
    tk(4);
    chk("cpu_power", 4'hF, oe_n);
    chk("charge", 4'h3, chg);
    flt <= 5'h01;
    tk(SC - 8);
    flt <= 5'h00;
    tk(DC + 10);
    chk("transient", 4'h0, oc);
    flt <= 5'h01;
    tk(3);
    flt <= 5'h00;
    tk(20);
    flt <= 5'h01;
    tk(3);
    flt <= 5'h00;
    tk(10);
    chk("double", 4'h1, oc);
    chk("irq_set", 1'b1, irq);
    rd(8'h08, {2'b00, 32'h1});
    tk(2);
    chk("irq_clear", 1'b0, irq);
    wr(8'h08, 32'h1);
    tk(2);
    chk("ack", 4'h0, oc);
    tk(DC + 10);
    flt <= 5'h02;
    tk(SC + 5);
    flt <= 5'h00;
    tk(5);
    chk("single", 4'h2, oc);
    chk("irq_masked", 1'b0, irq);
    rd(8'h08, {2'b00, 32'h2});
    wr(8'h00, 32'h3);
    tk(4);
    chk("gang_ports", 4'h0, oe_n);
    chk("gang_pin", 1'b1, sh_oe_n);
    flt <= 5'h10;
    tk(SC + 5);
    flt <= 5'h00;
    tk(5);
    chk("gang_fault", 4'hF, oc);
    rd(8'h10, {2'b00, 32'h0000_0FFF});
    rd(8'h00, {2'b00, 32'h0000_0003});
    strap <= 1'b1;
    rst <= 1'b1;
    tk(4);
    rst <= 1'b0;
    tk(2);
    chk("rst_event", 4'h0, oc);
    rd(8'h14, {2'b00, 32'h0});
    wrap_up;
  end
endmodule // ppoc_port_ctl_tb

// ---- verif/ppoc_switch_model.sv ----
// Purpose: External power switches, bit 4 is the ganged pin
// Assumes: Fault command low-pulls a released line
// Notes:   Undriven line without pull-up flips each cycle
`timescale 1ns/1ps
module ppoc_switch_model (
  // Clock
  input  wire       i_core_clk,
  // Device side
  input  wire [4:0] i_oe_n,
  input  wire [4:0] i_pu,
  input  wire [4:0] i_drv,
  input  wire [4:0] i_flt,
  // Resolved lines
  output wire [4:0] o_pin
);
  reg [4:0] last_q = 5'h00;
  always @(posedge i_core_clk) last_q <= o_pin;
  // Switch or blown fuse pulls low over the released driver
  // No power-good delay: fuse state is readable at release
  assign o_pin = (~i_oe_n & i_drv) | (i_oe_n & ~i_flt & (i_pu | ~last_q));
endmodule // ppoc_switch_model

// ---- verilog/ppoc_map.vh ----
// Purpose: Offsets, fields, reset values and timing for the port power block
// Assumes: 200 MHz core clock, AXI4-Lite byte addresses
// Notes:   Definitions only
`ifndef PPOC_MAP_VH
`define PPOC_MAP_VH

`define PPOC_CLK_MHZ        200
`define PPOC_SINGLE_MIN_MS  5
`define PPOC_DOUBLE_MAX_MS  20
`define PPOC_SINGLE_CYC     (`PPOC_SINGLE_MIN_MS * `PPOC_CLK_MHZ * 1000)
`define PPOC_DOUBLE_CYC     (`PPOC_DOUBLE_MAX_MS * `PPOC_CLK_MHZ * 1000)

`define PPOC_REG_CTRL       8'h00
`define PPOC_REG_PWR        8'h04
`define PPOC_REG_STAT       8'h08
`define PPOC_REG_MASK       8'h0C
`define PPOC_REG_PINS       8'h10
`define PPOC_REG_CHG        8'h14

`define PPOC_CTRL_GANG      0
`define PPOC_CTRL_CPU       1
`define PPOC_CTRL_RST       32'h0000_0000
`define PPOC_PWR_RST        4'h0
`define PPOC_MASK_RST       4'h0
`define PPOC_CHG_STRAP_LOW  4'h3
`define PPOC_CHG_STRAP_HIGH 4'h0

`define PPOC_RESP_OKAY      2'b00
`define PPOC_RESP_SLVERR    2'b10

`endif

// ---- verilog/ppoc_ocs_filter.v ----
// Purpose: Over-current filter for one sense input
// Assumes: Input synchronous to clock, low means fault
// Notes:   Single long low or two low groups inside a window
`timescale 1ns/1ps
module ppoc_ocs_filter #(
  parameter integer SINGLE_CYC = 1000000,
  parameter integer DOUBLE_CYC = 4000000,
  parameter integer CW         = 23
) (
  // Clock and reset
  input  wire          i_core_clk,
  input  wire          i_sys_rst,
  // Sense
  input  wire          i_enable,
  input  wire          i_sense,
  // Result
  output reg           o_fault
);
  reg  [CW-1:0] low_cnt_q;
  reg  [CW-1:0] win_cnt_q;
  reg           win_act_q;
  reg           prev_low_q;
  wire          low_now = i_enable & ~i_sense;
  wire          grp_start = low_now & ~prev_low_q;

  always @(posedge i_core_clk) begin
    if (i_sys_rst || !i_enable) begin
      low_cnt_q  <= {CW{1'b0}};
      win_cnt_q  <= {CW{1'b0}};
      win_act_q  <= 1'b0;
      prev_low_q <= 1'b0;
      o_fault    <= 1'b0;
    end else begin
      prev_low_q <= low_now;
      o_fault    <= 1'b0;
      if (low_now) begin
        if (low_cnt_q == SINGLE_CYC[CW-1:0] - 1'b1) begin
          o_fault <= 1'b1;
        end
        if (low_cnt_q != {CW{1'b1}}) begin
          low_cnt_q <= low_cnt_q + 1'b1;
        end
      end else begin
        low_cnt_q <= {CW{1'b0}}; // Short lows are transients
      end
      if (grp_start) begin
        if (win_act_q) begin
          o_fault   <= 1'b1;
          win_act_q <= 1'b0;
        end else begin
          win_act_q <= 1'b1;
          win_cnt_q <= {CW{1'b0}};
        end
      end else if (win_act_q) begin
        if (win_cnt_q == DOUBLE_CYC[CW-1:0] - 1'b1) begin
          win_act_q <= 1'b0;
        end
        win_cnt_q <= win_cnt_q + 1'b1;
      end
    end
  end
endmodule // ppoc_ocs_filter

// ---- verilog/ppoc_port_ctl.v ----
// Purpose: Port power control and over-current sense for a four-port hub
// Assumes: Pins synchronous to i_core_clk; AXI4-Lite register access
// Notes:   Open-drain pins: output enable low while driving low
//
// Notes on behaviour
// - One shared pin per port: power and sense
// - Hub logic or processor controls power
// - Ganged or combined mode selectable
// - Ganged: one pin serves all ports
// - Combined: separate pin for every port
// - Disabled: drive low, pull-up off
// - Enabled: release driver, pull-up on
// - External switch pulls low; release never masks
// - Filter transient lows while powering up
// - Sample pin continuously while enabled
// - Fault after low held 5 ms
// - Fault on two low groups in 20 ms
// - Poly fuse uses same drive and sense
// - Charge strap selects charging ports
// - Pins also indicate charging supply; the code shows it on o_charge_port_en only, not on the pins
`timescale 1ns/1ps
`include "ppoc_map.vh"
module ppoc_port_ctl #(
  parameter integer NPORT      = 4,
  parameter integer SINGLE_CYC = `PPOC_SINGLE_CYC,
  parameter integer DOUBLE_CYC = `PPOC_DOUBLE_CYC
) (
  // Clock and reset
  input  wire             i_core_clk,
  input  wire             i_sys_rst,
  // Hub logic power request and strap
  input  wire [NPORT-1:0] i_hub_pwr_req,
  input  wire             i_charge_enable_strap,
  // Per-port pins
  input  wire [NPORT-1:0] i_port_power_sense_pin,
  output reg  [NPORT-1:0] o_port_power_sense_pin,
  output reg  [NPORT-1:0] o_port_power_sense_pin_oe_n,
  output reg  [NPORT-1:0] o_port_pullup_en,
  // Ganged pin
  input  wire             i_shared_power_sense_pin,
  output reg              o_shared_power_sense_pin,
  output reg              o_shared_power_sense_pin_oe_n,
  output reg              o_shared_pullup_en,
  // Status to hub
  output reg  [NPORT-1:0] o_oc_event,
  output reg  [NPORT-1:0] o_charge_port_en,
  output reg              o_irq,
  // AXI4-Lite write
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output reg              s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output reg              s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output reg              s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready
);
  localparam integer CW = 27;

  reg  [31:0]      ctrl_q;
  reg  [NPORT-1:0] cpu_pwr_q;
  reg  [NPORT-1:0] stat_q;
  reg  [NPORT-1:0] mask_q;
  reg  [NPORT-1:0] chg_q;
  reg  [NPORT-1:0] pwr_en_q;
  reg              strap_done_q;
  reg  [7:0]       aw_addr_q;
  reg              aw_have_q;
  reg  [31:0]      w_data_q;
  reg  [3:0]       w_strb_q;
  reg              w_have_q;

  wire             gang_mode = ctrl_q[`PPOC_CTRL_GANG];
  wire [NPORT-1:0] pwr_req   = ctrl_q[`PPOC_CTRL_CPU] ? cpu_pwr_q : i_hub_pwr_req;
  wire             gang_req  = |pwr_req;
  wire [NPORT-1:0] fault;
  wire [NPORT-1:0] sense_in;
  wire [NPORT-1:0] sense_en;
  wire             do_write  = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire             do_read   = s_axi_arvalid & s_axi_arready;
  wire             stat_rd   = do_read & (s_axi_araddr == `PPOC_REG_STAT);
  wire [NPORT-1:0] stat_ack  = (do_write && aw_addr_q == `PPOC_REG_STAT) ? w_data_q[NPORT-1:0] : {NPORT{1'b0}};

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // Byte-lane merge of a charge-port write, cut to the port count
  wire [31:0]      chg_wr = merge({{(32-NPORT){1'b0}}, chg_q}, w_data_q, w_strb_q);

  // In ganged mode every filter watches the single shared pin
  assign sense_in = gang_mode ? {NPORT{i_shared_power_sense_pin}} : i_port_power_sense_pin;
  // Filters run only once the pin is really released; on a mode change the
  // still driven-low pin would otherwise count as a first low group
  assign sense_en = gang_mode ? {NPORT{o_shared_power_sense_pin_oe_n}} : o_port_power_sense_pin_oe_n;

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      ppoc_ocs_filter #(
        .SINGLE_CYC (SINGLE_CYC),
        .DOUBLE_CYC (DOUBLE_CYC),
        .CW         (CW)
      ) u_filt (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_enable   (sense_en[g]),
        .i_sense    (sense_in[g]),
        .o_fault    (fault[g])
      );
    end
  endgenerate

  // Pin drive and power state
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pwr_en_q                      <= `PPOC_PWR_RST;
      o_port_power_sense_pin        <= {NPORT{1'b0}};
      o_port_power_sense_pin_oe_n   <= {NPORT{1'b0}};
      o_port_pullup_en              <= {NPORT{1'b0}};
      o_shared_power_sense_pin      <= 1'b0;
      o_shared_power_sense_pin_oe_n <= 1'b0;
      o_shared_pullup_en            <= 1'b0;
    end else begin
      pwr_en_q <= gang_mode ? {NPORT{gang_req}} : pwr_req;
      o_port_power_sense_pin <= {NPORT{1'b0}};
      // Unused pins in ganged mode stay driven low, no pull-up power wasted
      o_port_power_sense_pin_oe_n <= gang_mode ? {NPORT{1'b0}} : pwr_req;
      o_port_pullup_en            <= gang_mode ? {NPORT{1'b0}} : pwr_req;
      o_shared_power_sense_pin      <= 1'b0;
      o_shared_power_sense_pin_oe_n <= gang_mode & gang_req;
      o_shared_pullup_en            <= gang_mode & gang_req;
    end
  end

  // Fault latch, strap capture, interrupt
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      stat_q           <= {NPORT{1'b0}};
      o_oc_event       <= {NPORT{1'b0}};
      chg_q            <= {NPORT{1'b0}};
      strap_done_q     <= 1'b0;
      o_charge_port_en <= {NPORT{1'b0}};
      o_irq            <= 1'b0;
    end else begin
      // Set wins over clear in the same cycle
      stat_q     <= (stat_rd ? {NPORT{1'b0}} : stat_q) | fault;
      o_oc_event <= (o_oc_event & ~stat_ack & ~(pwr_req & ~pwr_en_q)) | fault;
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        chg_q <= i_charge_enable_strap ? `PPOC_CHG_STRAP_HIGH : `PPOC_CHG_STRAP_LOW;
      end else if (do_write && aw_addr_q == `PPOC_REG_CHG) begin
        chg_q <= chg_wr[NPORT-1:0];
      end
      o_charge_port_en <= chg_q & pwr_en_q;
      o_irq <= |(((stat_rd ? {NPORT{1'b0}} : stat_q) | fault) & mask_q);
    end
  end

  // AXI4-Lite write channel
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PPOC_RESP_OKAY;
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_have_q      <= 1'b0;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      ctrl_q        <= `PPOC_CTRL_RST;
      cpu_pwr_q     <= `PPOC_PWR_RST;
      mask_q        <= `PPOC_MASK_RST;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PPOC_RESP_OKAY;
        case (aw_addr_q)
          `PPOC_REG_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_0003;
          `PPOC_REG_PWR:  cpu_pwr_q <= w_strb_q[0] ? w_data_q[NPORT-1:0] : cpu_pwr_q;
          `PPOC_REG_MASK: mask_q <= w_strb_q[0] ? w_data_q[NPORT-1:0] : mask_q;
          `PPOC_REG_STAT: s_axi_bresp <= `PPOC_RESP_OKAY;
          `PPOC_REG_CHG:  s_axi_bresp <= `PPOC_RESP_OKAY;
          `PPOC_REG_PINS: s_axi_bresp <= `PPOC_RESP_OKAY;
          default:        s_axi_bresp <= `PPOC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PPOC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~s_axi_arvalid ? 1'b1 : (~s_axi_rvalid & ~s_axi_arready);
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `PPOC_RESP_OKAY;
        s_axi_rdata   <= 32'h0000_0000;
        case (s_axi_araddr)
          `PPOC_REG_CTRL: s_axi_rdata <= ctrl_q;
          `PPOC_REG_PWR:  s_axi_rdata <= {28'h0, cpu_pwr_q};
          `PPOC_REG_STAT: s_axi_rdata <= {28'h0, stat_q};
          `PPOC_REG_MASK: s_axi_rdata <= {28'h0, mask_q};
          `PPOC_REG_PINS: s_axi_rdata <= {20'h0, o_oc_event, pwr_en_q, sense_in};
          `PPOC_REG_CHG:  s_axi_rdata <= {28'h0, chg_q};
          default:        s_axi_rresp <= `PPOC_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ppoc_port_ctl
